// ---- common/ovl_pkg.sv ----
// constants for the paged output voltage limit command bank
// Function
// - output format byte is 3-bit linear mode plus 5-bit exponent, reads 0x14
// - output format command is read-only; writes never change the exponent
// - each page holds 16-bit nominal set-point at 0x21, reset 0x1000
// - applied voltage, margin high included, clamps to per-page ceiling
// - overvoltage fault when sensed output exceeds threshold at 0x40
// - busy after overvoltage fault threshold change drives common status bits 5 and 6 low
// - low-side clamp response: no gpio, high gate off, low gate on
// - reading above warning 0x42 sets status bits and raises alert
// - adc warnings and power good detected within 90 ms
// - margin high moves output to value at 0x25, host keeps it above nominal
// - margin low moves output to value at 0x26, host keeps it below nominal
// - set-point writes ignored during turn-on rise or turn-off fall
// - steady-state set-point change ramps at transition rate, no step
// - reading below warning 0x43 sets status bits and raises alert
// - undervoltage fault when sensed output crosses threshold at 0x44
// - power good asserts at or above threshold at 0x5E
// - power good negates at or below threshold at 0x5F
// - power good never raises alert; power_good output tracks comparison
// - readback ceiling by range: 4.096/5.5 V high, 2.75 V low
// - nominal above device ceiling flags logic fault and clamps output
// - power good pin reads high at power-up before any comparison
package ovl_pkg;
   localparam logic [7:0]  CMD_FORMAT      = 8'h20;
   localparam logic [7:0]  CMD_NOMINAL     = 8'h21;
   localparam logic [7:0]  CMD_CEILING     = 8'h24;
   localparam logic [7:0]  CMD_MARGIN_HI   = 8'h25;
   localparam logic [7:0]  CMD_MARGIN_LO   = 8'h26;
   localparam logic [7:0]  CMD_OV_FAULT    = 8'h40;
   localparam logic [7:0]  CMD_OV_WARN     = 8'h42;
   localparam logic [7:0]  CMD_UV_WARN     = 8'h43;
   localparam logic [7:0]  CMD_UV_FAULT    = 8'h44;
   localparam logic [7:0]  CMD_PG_ON       = 8'h5E;
   localparam logic [7:0]  CMD_PG_OFF      = 8'h5F;
   localparam logic [7:0]  CMD_DEV_CEILING = 8'hA5;
   localparam logic [7:0]  FORMAT_VALUE    = 8'h14;
   localparam logic [15:0] RST_NOMINAL     = 16'h1000;
   localparam logic [15:0] RST_CEILING0    = 16'h4189;
   localparam logic [15:0] RST_CEILING1    = 16'h5800;
   localparam logic [15:0] RST_MARGIN_HI   = 16'h10CD;
   localparam logic [15:0] RST_MARGIN_LO   = 16'h0F33;
   localparam logic [15:0] RST_OV_FAULT    = 16'h119A;
   localparam logic [15:0] RST_OV_WARN     = 16'h1133;
   localparam logic [15:0] RST_UV_WARN     = 16'h0ECD;
   localparam logic [15:0] RST_UV_FAULT    = 16'h0E66;
   localparam logic [15:0] RST_PG_ON       = 16'h0EE1;
   localparam logic [15:0] RST_PG_OFF      = 16'h0EB8;
   // 4.096 V, 5.5 V and 2.75 V at the 2^-12 step
   localparam logic [15:0] DEV_MAX_HI0     = 16'h4189;
   localparam logic [15:0] DEV_MAX_HI1     = 16'h5800;
   localparam logic [15:0] DEV_MAX_LO      = 16'h2C00;
   // status bit positions
   localparam int          STS_OV_WARN     = 7;
   localparam int          STS_UV_WARN     = 5;
   localparam int          STS_OV_FAULT    = 6;
   localparam int          STS_UV_FAULT    = 4;
   localparam int          WORD_VOUT       = 15;
   localparam int          WORD_PGOOD_N    = 11;
   localparam int          BYTE_NOTA       = 0;
   localparam int          COMMON_BUSY_A   = 5;
   localparam int          COMMON_BUSY_B   = 6;
   // timing
   localparam int          CLK_HZ          = 20_000_000;
   localparam int          RECALC_US       = 10_000;
   localparam int          RECALC_CYCLES   = RECALC_US * (CLK_HZ / 1_000_000);
   localparam logic [1:0]  OP_NOMINAL      = 2'h0;
   localparam logic [1:0]  OP_MARGIN_LO    = 2'h1;
   localparam logic [1:0]  OP_MARGIN_HI    = 2'h2;
   typedef enum logic [1:0] {
      SEQ_OFF    = 2'b00,
      SEQ_RISE   = 2'b01,
      SEQ_STEADY = 2'b10,
      SEQ_FALL   = 2'b11
   } ovl_seq_type;
endpackage

// ---- dv/ovl_bank_assertions.sv ----
// concurrent checks on the output voltage limit bank ports
`timescale 1ns/1ps
module ovl_bank_assertions #(
   parameter int RECALC_CYCLES = ovl_pkg::RECALC_CYCLES
) (
   // clock and reset
   input wire logic            clk,
   input wire logic            rst,
   // stimulus
   input wire logic            cmd_write,
   input wire logic [7:0]      cmd_code,
   input wire logic            status_clear,
   input wire logic            ov_clamp_response,
   input wire logic            adc_valid,
   // results
   input wire logic [15:0]     cmd_rdata,
   input wire logic [1:0]      high_side_gate,
   input wire logic [1:0]      low_side_gate,
   input wire logic            gpio_fault,
   input wire logic            alert,
   input wire logic            logic_fault,
   input wire logic [7:0]      common_status_register,
   input wire logic [1:0][7:0] status_vout
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic        busy;
   logic [31:0] busy_len;
   assign busy = common_status_register[6:5] != 2'b11;
   // run length of busy, too long a run would hold off host set-point writes for up to 99 cycles
   always_ff @(posedge clk) begin
      if (rst) begin
         busy_len <= 32'h0;
      end else begin
         busy_len <= busy ? busy_len + 32'h1 : 32'h0;
      end
   end
   sequence ov_hit;
      status_vout[0][6] && ov_clamp_response;
   endsequence
   sequence clamp_on;
      !high_side_gate[0] && low_side_gate[0];
   endsequence
   ////////////////////////////////////////
   a_format_read: assert property (
      cmd_code == 8'h20 |=> cmd_rdata == 16'h0014) else $error("bad format");
   a_busy_start: assert property (
      cmd_write && cmd_code == 8'h40 |=> busy) else $error("no busy");
   a_busy_len: assert property (
      busy_len <= RECALC_CYCLES) else $error("busy too long");
   a_status_cause: assert property (
      (status_vout & ~$past(status_vout)) != 16'h0 |-> $past(adc_valid))
      else $error("status set without sample");
   a_status_latch: assert property (
      !status_clear |=> (status_vout & $past(status_vout)) == $past(status_vout))
      else $error("status lost");
   a_alert_raise: assert property (
      (|status_vout) || logic_fault |=> alert) else $error("alert missing");
   a_alert_quiet: assert property (
      status_vout == 16'h0 && !logic_fault |=> !alert) else $error("alert stray");
   a_clamp_gate: assert property (
      ov_hit |-> ##[0:1] clamp_on) else $error("clamp gates wrong");
   a_gpio_mask: assert property (
      ov_clamp_response ##1 ov_clamp_response |-> !gpio_fault)
      else $error("gpio under clamp");
endmodule
bind ovl_bank ovl_bank_assertions #(.RECALC_CYCLES(RECALC_CYCLES)) u_chk (
   .clk(clk), .rst(rst), .cmd_write(cmd_write), .cmd_code(cmd_code),
   .status_clear(status_clear), .ov_clamp_response(ov_clamp_response),
   .adc_valid(adc_valid), .cmd_rdata(cmd_rdata),
   .high_side_gate(high_side_gate), .low_side_gate(low_side_gate),
   .gpio_fault(gpio_fault), .alert(alert), .logic_fault(logic_fault),
   .common_status_register(common_status_register),
   .status_vout(status_vout));

// ---- dv/ovl_bank_test.sv ----
// self-checking bench for the output voltage limit bank
`timescale 1ns/1ps
module ovl_bank_test;
   logic clk = 0, rst = 1, status_clear = 0, low_range = 0, clamp = 1;
   logic ramp_tick = 0, adc_valid = 0, adc_page = 0, obs_go = 0;
   logic cmd_write, cmd_page, gpio_fault, alert, logic_fault;
   logic [1:0] mode = 0, phase = 2, power_good, hs_gate, ls_gate;
   logic [2:0] obs_sel = 0;
   logic [7:0] cmd_code, common_status;
   logic [15:0] cmd_wdata, cmd_rdata, rnd, adc_vout = 0;
   logic [1:0][15:0] applied;
   logic [1:0][7:0] status_vout;
   logic [5:0][15:0] obs;
   logic [15:0] exp_q [$];
   int err_total = 0, tests_run = 0, cycles = 0, seed = 71874;
   string nm [6] = '{"rdata", "applied0", "applied1", "status", "flags", "common"};
   logic [7:0] codes [13] = '{8'h20, 8'h21, 8'h24, 8'h25, 8'h26, 8'h40,
      8'h42, 8'h43, 8'h44, 8'h5E, 8'h5F, 8'hA5, 8'h30};
   logic [15:0] e0 [13] = '{16'h0014, 16'h1000, 16'h4189, 16'h10CD, 16'h0F33,
      16'h119A, 16'h1133, 16'h0ECD, 16'h0E66, 16'h0EE1, 16'h0EB8, 16'h4189, 0};
   logic [15:0] e1 [13] = '{16'h0014, 16'h1000, 16'h5800, 16'h10CD, 16'h0F33,
      16'h119A, 16'h1133, 16'h0ECD, 16'h0E66, 16'h0EE1, 16'h0EB8, 16'h5800, 0};
   assign obs = {8'h00, common_status, 7'h00, gpio_fault, alert, logic_fault,
      power_good, hs_gate, ls_gate, status_vout, applied, cmd_rdata};
   always #25 clk = ~clk;
   ovl_bank #(.RECALC_CYCLES(20)) u_ovl_bank (.clk(clk), .rst(rst),
      .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_page(cmd_page),
      .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .status_clear(status_clear),
      .operation_mode(mode), .seq_phase(phase), .low_range(low_range),
      .ov_clamp_response(clamp), .ramp_tick(ramp_tick), .adc_valid(adc_valid),
      .adc_page(adc_page), .adc_vout(adc_vout), .applied_setpoint(applied),
      .high_side_gate(hs_gate), .low_side_gate(ls_gate), .alert(alert),
      .gpio_fault(gpio_fault), .power_good(power_good), .logic_fault(logic_fault),
      .common_status_register(common_status), .status_vout(status_vout));
   ovl_host u_ovl_host (.clk(clk), .common_status_register(common_status),
      .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_page(cmd_page),
      .cmd_wdata(cmd_wdata));
   ////////////////////////////////////////
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic cmp(string what, logic [15:0] seen, logic [15:0] want);
      tests_run++;
      if (seen !== want) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", what, want, seen);
      end
   endtask
   always @(posedge clk) begin
      cycles++;
      if (obs_go) begin
         cmp(nm[obs_sel], obs[obs_sel], exp_q.pop_front());
      end
      if (cycles == 3000) begin
         err_total++;
         give_verdict();
      end
   end
   task automatic tick(int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic check(logic [2:0] s, logic [15:0] v);
      exp_q.push_back(v);
      obs_sel <= s;
      obs_go <= 1'b1;
      tick(1);
      obs_go <= 1'b0;
      tick(1);
   endtask
   task automatic rd(logic [7:0] c, logic p, logic [15:0] v);
      u_ovl_host.sel(c, p);
      check(0, v);
   endtask
   task automatic sample(logic p, logic [15:0] v);
      adc_page <= p;
      adc_vout <= v;
      adc_valid <= 1'b1;
      tick(1);
      adc_valid <= 1'b0;
      tick(3);
   endtask
   task automatic clear_status();
      status_clear <= 1'b1;
      tick(1);
      status_clear <= 1'b0;
      tick(2);
   endtask
   initial begin
      tick(5);
      rst <= 1'b0;
      check(4, 16'h003C);
      check(5, 16'h00FF);
      for (int i = 0; i < 26; i++) begin
         rd(codes[i % 13], i / 13, i < 13 ? e0[i % 13] : e1[i % 13]);
      end
      low_range <= 1'b1;
      rd(8'hA5, 1'b0, 16'h2C00);
      rd(8'hA5, 1'b1, 16'h2C00);
      low_range <= 1'b0;
      rnd = $random(seed);
      u_ovl_host.wr(8'h20, 1'b0, rnd);
      rd(8'h20, 1'b0, 16'h0014);
      u_ovl_host.wr(8'h26, 1'b1, {4'h0, rnd[11:0]});
      rd(8'h26, 1'b1, {4'h0, rnd[11:0]});
      $display("test registers done");
      for (int ph = 1; ph < 4; ph += 2) begin
         phase <= ph[1:0];
         u_ovl_host.wr(8'h21, 1'b0, 16'h1004);
         rd(8'h21, 1'b0, 16'h1000);
         u_ovl_host.wr(8'h25, 1'b0, 16'h1111);
         rd(8'h25, 1'b0, 16'h10CD);
      end
      phase <= 2'h2;
      u_ovl_host.wr(8'h21, 1'b0, 16'h1004);
      check(1, 16'h1000);
      repeat (4) begin
         ramp_tick <= 1'b1;
         tick(1);
         ramp_tick <= 1'b0;
         tick(1);
      end
      check(1, 16'h1004);
      u_ovl_host.wr(8'h40, 1'b0, 16'h1200);
      check(5, 16'h009F);
      u_ovl_host.wr(8'h21, 1'b0, 16'h1010);
      $display("test set-point done");
      phase <= 2'h0;
      u_ovl_host.wr(8'h24, 1'b0, 16'h1050);
      mode <= 2'h2;
      tick(2);
      check(1, 16'h1050);
      mode <= 2'h1;
      tick(2);
      check(1, 16'h0F33);
      check(2, {4'h0, rnd[11:0]});
      mode <= 2'h0;
      tick(2);
      check(1, 16'h1010);
      u_ovl_host.wr(8'h24, 1'b0, 16'hFFFF);
      u_ovl_host.wr(8'h21, 1'b0, 16'h5000);
      tick(2);
      check(1, 16'h4189);
      check(4, 16'h00FC);
      clear_status();
      $display("test margin done");
      sample(1'b0, 16'h1140);
      check(3, 16'h0080);
      sample(1'b0, 16'h1300);
      check(4, 16'h00B9);
      sample(1'b0, 16'h1000);
      check(3, 16'h00C0);
      clamp <= 1'b0;
      sample(1'b1, 16'h1200);
      check(4, 16'h01B9);
      clear_status();
      check(4, 16'h0039);
      sample(1'b1, 16'h0EC0);
      check(3, 16'h2000);
      sample(1'b1, 16'h0E00);
      check(3, 16'h3000);
      check(4, 16'h0099);
      clear_status();
      sample(1'b1, 16'h0EE1);
      check(4, 16'h0039);
      $display("test monitor done");
      give_verdict();
   end
endmodule

// ---- dv/ovl_host.sv ----
// host model driving the command port
`timescale 1ns/1ps
module ovl_host (
   // clock and device status
   input  wire logic       clk,
   input  wire logic [7:0] common_status_register,
   // command port
   output logic            cmd_write = 1'b0,
   output logic      [7:0] cmd_code = 8'h00,
   output logic            cmd_page = 1'b0,
   output logic     [15:0] cmd_wdata = 16'h0000
);
   task automatic sel(logic [7:0] c, logic p);
      cmd_code <= c;
      cmd_page <= p;
      @(posedge clk);
   endtask
   task automatic wr(logic [7:0] c, logic p, logic [15:0] d);
      int n;
      n = 0;
      // raising the set-point mid recalculation risks a false fault
      while (c == 8'h21 && common_status_register[6:5] != 2'b11 && n < 99) begin
         n++;
         @(posedge clk);
      end
      cmd_code <= c;
      cmd_page <= p;
      cmd_wdata <= d;
      cmd_write <= 1'b1;
      @(posedge clk);
      cmd_write <= 1'b0;
      cmd_wdata <= ~d;
      @(posedge clk);
   endtask
endmodule

// ---- rtl/ovl_bank.sv ----
// paged output voltage set-point, limit and status bank
`timescale 1ns/1ps
module ovl_bank #(
   parameter int PAGES         = 2,
   parameter int RECALC_CYCLES = ovl_pkg::RECALC_CYCLES
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // command port from the framing layer
   input  wire logic        cmd_write,
   input  wire logic [7:0]  cmd_code,
   input  wire logic        cmd_page,
   input  wire logic [15:0] cmd_wdata,
   output logic      [15:0] cmd_rdata,
   input  wire logic        status_clear,
   // operating context, same clock
   input  wire logic [1:0]  operation_mode,
   input  wire logic [1:0]  seq_phase,
   input  wire logic        low_range,
   input  wire logic        ov_clamp_response,
   input  wire logic        ramp_tick,
   input  wire logic        adc_valid,
   input  wire logic        adc_page,
   input  wire logic [15:0] adc_vout,
   // outputs
   output logic [1:0][15:0] applied_setpoint,
   output logic      [1:0]  high_side_gate,
   output logic      [1:0]  low_side_gate,
   output logic             gpio_fault,
   output logic             alert,
   output logic      [1:0]  power_good,
   output logic             logic_fault,
   output logic      [7:0]  common_status_register,
   output logic      [1:0][7:0] status_vout
);
   ////////////////////////////////////////////////////////////////////////
   logic [1:0][15:0] nominal, ceiling, margin_hi, margin_lo;
   logic [1:0][15:0] ov_fault, ov_warn, uv_warn, uv_fault, pg_on, pg_off;
   logic [1:0][15:0] target;
   logic [1:0][15:0] dev_max;
   logic [31:0]      busy_count;
   logic             set_ok;
   logic [15:0]      next_rdata;

   // set-point and margin writes refused while the output is sequencing
   assign set_ok = (seq_phase != ovl_pkg::SEQ_RISE)
                 && (seq_phase != ovl_pkg::SEQ_FALL);

   genvar p;
   generate
      for (p = 0; p < 2; p++) begin : g_page
         logic [15:0] sel;
         logic [15:0] lim;
         always_comb begin
            sel = nominal[p];
            if (operation_mode == ovl_pkg::OP_MARGIN_HI) begin
               sel = margin_hi[p];
            end else if (operation_mode == ovl_pkg::OP_MARGIN_LO) begin
               sel = margin_lo[p];
            end
            dev_max[p] = low_range ? ovl_pkg::DEV_MAX_LO
                       : (p == 0 ? ovl_pkg::DEV_MAX_HI0
                                 : ovl_pkg::DEV_MAX_HI1);
            lim = (ceiling[p] < dev_max[p]) ? ceiling[p] : dev_max[p];
            target[p] = (sel > lim) ? lim : sel;
         end

         always_ff @(posedge clk) begin
            if (rst) begin
               nominal[p]   <= ovl_pkg::RST_NOMINAL;
               ceiling[p]   <= (p == 0) ? ovl_pkg::RST_CEILING0
                                        : ovl_pkg::RST_CEILING1;
               margin_hi[p] <= ovl_pkg::RST_MARGIN_HI;
               margin_lo[p] <= ovl_pkg::RST_MARGIN_LO;
               ov_fault[p]  <= ovl_pkg::RST_OV_FAULT;
               ov_warn[p]   <= ovl_pkg::RST_OV_WARN;
               uv_warn[p]   <= ovl_pkg::RST_UV_WARN;
               uv_fault[p]  <= ovl_pkg::RST_UV_FAULT;
               pg_on[p]     <= ovl_pkg::RST_PG_ON;
               pg_off[p]    <= ovl_pkg::RST_PG_OFF;
            end else if (cmd_write && cmd_page == p) begin
               // format code has no storage, so writes cannot touch it
               if (cmd_code == ovl_pkg::CMD_NOMINAL && set_ok) begin
                  nominal[p] <= cmd_wdata;
               end else if (cmd_code == ovl_pkg::CMD_CEILING) begin
                  ceiling[p] <= cmd_wdata;
               end else if (cmd_code == ovl_pkg::CMD_MARGIN_HI && set_ok) begin
                  margin_hi[p] <= cmd_wdata;
               end else if (cmd_code == ovl_pkg::CMD_MARGIN_LO && set_ok) begin
                  margin_lo[p] <= cmd_wdata;
               end else if (cmd_code == ovl_pkg::CMD_OV_FAULT) begin
                  ov_fault[p] <= cmd_wdata;
               end else if (cmd_code == ovl_pkg::CMD_OV_WARN) begin
                  ov_warn[p] <= cmd_wdata;
               end else if (cmd_code == ovl_pkg::CMD_UV_WARN) begin
                  uv_warn[p] <= cmd_wdata;
               end else if (cmd_code == ovl_pkg::CMD_UV_FAULT) begin
                  uv_fault[p] <= cmd_wdata;
               end else if (cmd_code == ovl_pkg::CMD_PG_ON) begin
                  pg_on[p] <= cmd_wdata;
               end else if (cmd_code == ovl_pkg::CMD_PG_OFF) begin
                  pg_off[p] <= cmd_wdata;
               end
            end
         end

         // applied value ramps one step per tick once in steady state
         always_ff @(posedge clk) begin
            if (rst) begin
               applied_setpoint[p] <= ovl_pkg::RST_NOMINAL;
            end else if (seq_phase != ovl_pkg::SEQ_STEADY) begin
               if (set_ok) begin
                  applied_setpoint[p] <= target[p];
               end
            end else if (ramp_tick) begin
               if (applied_setpoint[p] < target[p]) begin
                  applied_setpoint[p] <= applied_setpoint[p] + 16'h0001;
               end else if (applied_setpoint[p] > target[p]) begin
                  applied_setpoint[p] <= applied_setpoint[p] - 16'h0001;
               end
            end
         end

         // comparisons evaluated on each adc sample, well inside 90 ms
         wire hit = adc_valid && (adc_page == p);
         always_ff @(posedge clk) begin
            if (rst) begin
               status_vout[p]    <= 8'h00;
               power_good[p]     <= 1'b1;
               high_side_gate[p] <= 1'b1;
               low_side_gate[p]  <= 1'b0;
            end else begin
               if (status_clear) begin
                  status_vout[p] <= 8'h00;
               end
               if (hit) begin
                  if (adc_vout > ov_warn[p]) begin
                     status_vout[p][ovl_pkg::STS_OV_WARN] <= 1'b1;
                  end
                  if (adc_vout < uv_warn[p]) begin
                     status_vout[p][ovl_pkg::STS_UV_WARN] <= 1'b1;
                  end
                  if (adc_vout > ov_fault[p]) begin
                     status_vout[p][ovl_pkg::STS_OV_FAULT] <= 1'b1;
                     if (ov_clamp_response) begin
                        high_side_gate[p] <= 1'b0;
                        low_side_gate[p]  <= 1'b1;
                     end
                  end
                  if (adc_vout < uv_fault[p]) begin
                     status_vout[p][ovl_pkg::STS_UV_FAULT] <= 1'b1;
                  end
                  if (adc_vout >= pg_on[p]) begin
                     power_good[p] <= 1'b1;
                  end else if (adc_vout <= pg_off[p]) begin
                     power_good[p] <= 1'b0;
                  end
               end
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // gpio only for propagated faults not handled by the clamp
   always_ff @(posedge clk) begin
      if (rst) begin
         gpio_fault <= 1'b0;
      end else begin
         gpio_fault <= !ov_clamp_response
                    && (status_vout[0][ovl_pkg::STS_OV_FAULT]
                     || status_vout[1][ovl_pkg::STS_OV_FAULT]);
      end
   end

   // power good deliberately absent from the alert term
   always_ff @(posedge clk) begin
      if (rst) begin
         alert <= 1'b0;
      end else begin
         alert <= |status_vout[0] || |status_vout[1] || logic_fault;
      end
   end

   // sticky; a new violation wins over the clear
   always_ff @(posedge clk) begin
      if (rst) begin
         logic_fault <= 1'b0;
      end else if (cmd_write && cmd_code == ovl_pkg::CMD_NOMINAL
                   && set_ok && cmd_wdata > dev_max[cmd_page]) begin
         logic_fault <= 1'b1;
      end else if (status_clear) begin
         logic_fault <= 1'b0;
      end
   end

   // recalculation window after overvoltage fault threshold writes
   always_ff @(posedge clk) begin
      if (rst) begin
         busy_count <= 32'h00000000;
      end else if (cmd_write && cmd_code == ovl_pkg::CMD_OV_FAULT) begin
         busy_count <= 32'(RECALC_CYCLES);
      end else if (busy_count != 32'h00000000) begin
         busy_count <= busy_count - 32'h00000001;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         common_status_register <= 8'hFF;
      end else begin
         common_status_register <= 8'hFF;
         common_status_register[ovl_pkg::COMMON_BUSY_A] <=
            !(busy_count > 32'h00000001) && !(cmd_write
            && cmd_code == ovl_pkg::CMD_OV_FAULT);
         common_status_register[ovl_pkg::COMMON_BUSY_B] <=
            !(busy_count > 32'h00000001) && !(cmd_write
            && cmd_code == ovl_pkg::CMD_OV_FAULT);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_rdata = 16'h0000;
      if (cmd_code == ovl_pkg::CMD_FORMAT) begin
         next_rdata = {8'h00, ovl_pkg::FORMAT_VALUE};
      end else if (cmd_code == ovl_pkg::CMD_NOMINAL) begin
         next_rdata = nominal[cmd_page];
      end else if (cmd_code == ovl_pkg::CMD_CEILING) begin
         next_rdata = ceiling[cmd_page];
      end else if (cmd_code == ovl_pkg::CMD_MARGIN_HI) begin
         next_rdata = margin_hi[cmd_page];
      end else if (cmd_code == ovl_pkg::CMD_MARGIN_LO) begin
         next_rdata = margin_lo[cmd_page];
      end else if (cmd_code == ovl_pkg::CMD_OV_FAULT) begin
         next_rdata = ov_fault[cmd_page];
      end else if (cmd_code == ovl_pkg::CMD_OV_WARN) begin
         next_rdata = ov_warn[cmd_page];
      end else if (cmd_code == ovl_pkg::CMD_UV_WARN) begin
         next_rdata = uv_warn[cmd_page];
      end else if (cmd_code == ovl_pkg::CMD_UV_FAULT) begin
         next_rdata = uv_fault[cmd_page];
      end else if (cmd_code == ovl_pkg::CMD_PG_ON) begin
         next_rdata = pg_on[cmd_page];
      end else if (cmd_code == ovl_pkg::CMD_PG_OFF) begin
         next_rdata = pg_off[cmd_page];
      end else if (cmd_code == ovl_pkg::CMD_DEV_CEILING) begin
         next_rdata = dev_max[cmd_page];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cmd_rdata <= 16'h0000;
      end else begin
         cmd_rdata <= next_rdata;
      end
   end
endmodule
